// ==== src/lpu_consts.vh ====
/*
  constants of the pixel unpack and display timing block: register byte
  offsets, field positions, reset values and mode codes.
  assumes it is included once per file by its bare name.
*/
`ifndef LPU_CONSTS_VH
`define LPU_CONSTS_VH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define LPU_OFS_CTRL1 12'h000
`define LPU_OFS_CTRL2 12'h004
`define LPU_OFS_CTRL3 12'h008
`define LPU_OFS_CTRL4 12'h00c
`define LPU_OFS_CTRL5 12'h010
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LPU_RST_WORD 32'h0000_0000
// ----------------------------------------------------------------------
// control one fields
// ----------------------------------------------------------------------
`define LPU_C1_ENABLE 0
`define LPU_C1_BPP 4:1
`define LPU_C1_PANEL 6:5
`define LPU_C1_ACSEL 7
`define LPU_C1_DIV 17:8
`define LPU_C1_LINE_COUNT_STATUS 27:18
// ----------------------------------------------------------------------
// control two to four fields
// ----------------------------------------------------------------------
`define LPU_C2_VBP 31:24
`define LPU_C2_VSIZE 23:14
`define LPU_C2_VFP 13:6
`define LPU_C2_VSW 5:0
`define LPU_C3_HBP 31:24
`define LPU_C3_HSIZE 18:8
`define LPU_C3_HFP 7:0
`define LPU_C4_ACCNT 15:8
`define LPU_C4_HSW 7:0
// ----------------------------------------------------------------------
// control five fields
// ----------------------------------------------------------------------
`define LPU_C5_SELF_REFRESH_ENABLE 0
`define LPU_C5_BSWAP 1
`define LPU_C5_HWSWAP 2
`define LPU_C5_SR_ACTIVE 8
`define LPU_C5_VISIBLE 9
// ----------------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------------
`define LPU_PANEL_ACTIVE 2'h3
`define LPU_BPP_P1 4'h0
`define LPU_BPP_P2 4'h1
`define LPU_BPP_P4 4'h2
`define LPU_BPP_P8 4'h3
`define LPU_BPP_P12 4'h4
`define LPU_BPP_A1 4'h8
`define LPU_BPP_A2 4'h9
`define LPU_BPP_A4 4'ha
`define LPU_BPP_A8 4'hb
`define LPU_BPP_A16 4'hc
`define LPU_STN_MIN_DIV 10'h001
`endif

// ==== src/lpu_unpack.v ====
/*
  pixel selector: picks one pixel out of a buffered group of frame words.
  assumes the caller holds the group stable and walks the index in order.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpu_consts.vh"
module lpu_unpack (
  input wire [95:0] group_words,
  input wire [4:0] pixel_index,
  input wire [3:0] bpp_mode,
  input wire byte_swap,
  input wire halfword_swap,
  output reg [15:0] pixel
);
  // ----------------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------------
  wire [31:0] w0 = group_words[95:64]; // first word of the group
  reg [6:0] nib; // nibble position from the top of the group
  reg [4:0] bi; // bit index within the word
  reg [1:0] byte_no; // byte within the word
  // combinational pick of the current pixel
  always @* begin
    nib = 7'h00;
    bi = 5'h00;
    byte_no = 2'h0;
    pixel = 16'h0000;
    case (bpp_mode)
      `LPU_BPP_P12: begin
        // three nibbles per pixel, msb first across three words
        nib = {2'h0, pixel_index} * 7'h03;
        pixel = {4'h0, group_words[7'h5f - {nib[4:0], 2'h0} -: 4],
          group_words[7'h5b - {nib[4:0], 2'h0} -: 4],
          group_words[7'h57 - {nib[4:0], 2'h0} -: 4]};
      end
      `LPU_BPP_A16: begin
        // upper half first unless halfword swap
        if (pixel_index[0] ^ halfword_swap) begin
          pixel = w0[15:0];
        end else begin
          pixel = w0[31:16];
        end
      end
      `LPU_BPP_P8, `LPU_BPP_A8: begin
        byte_no = byte_swap ? pixel_index[1:0] : 2'h3 - pixel_index[1:0];
        pixel = {8'h00, w0[{byte_no, 3'h7} -: 8]};
      end
      `LPU_BPP_P4, `LPU_BPP_A4: begin
        // swap moves whole bytes, nibble order inside a byte is kept
        byte_no = byte_swap ? pixel_index[2:1] : 2'h3 - pixel_index[2:1];
        pixel = {12'h000, w0[{byte_no, ~pixel_index[0], 2'h3} -: 4]};
      end
      `LPU_BPP_P2, `LPU_BPP_A2: begin
        bi = 5'h1f - {pixel_index[3:0], 1'b0};
        pixel = {14'h0000, w0[bi -: 2]};
      end
      default: begin
        bi = 5'h1f - pixel_index;
        pixel = {15'h0000, w0[bi]};
      end
    endcase
  end
endmodule // lpu_unpack
`default_nettype wire

// ==== src/lpu_top.v ====
/*
  pixel unpack and display timing block with an apb register slave.
  assumes a frame-buffer master feeding words on the same clock, palette
  lookup outside this block, and an apb master on SYS_CLK.
*/
// What this block does
// - 12 bpp unpacks three words into eight pixels
// - self-refresh begins at the next line start
// - self-refresh freezes pixel clock low and data
// - clearing the control bit leaves self-refresh
// - passive data shifts on pixel clock, line pulse
// - ac bias toggles per frame or per lines
// - select bit chooses frame or count rate
// - active mode makes syncs, clock, enable, line end
// - frame pulse marks each frame start
// - active pixel clock is bus over twice divider+1
// - frame period sums sync, porches, visible lines
// - palette modes 1/2/4/8 bpp, direct 16 bpp
// - 16 bpp upper half first, swap reverses
// - unswapped pixels taken from word msb down
// - byte swap uses low byte first in 4 and 8 bpp
// - keeps running alone on its divided clock
// - line count status counts vertical size down
`timescale 1ns/1ps
`default_nettype none
`include "lpu_consts.vh"
module lpu_top (
  input wire SYS_CLK,
  input wire RESETN,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire [31:0] FRAME_WORD,
  input wire FRAME_WORD_VALID,
  output wire FRAME_WORD_READY,
  output wire [15:0] VIDEO_DATA_OUT,
  output wire PIXEL_CLOCK_OUT,
  output wire FRAME_PULSE_OUT,
  output wire LINE_PULSE_OUT,
  output wire DATA_ENABLE_OUT,
  output wire LINE_END_OUT,
  output wire AC_BIAS_OUT
);
  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  reg [31:0] ctrl1_reg; // enable, bpp, panel, ac select, divider
  reg [31:0] ctrl2_reg; // vertical timing
  reg [31:0] ctrl3_reg; // horizontal size and porches
  reg [31:0] ctrl4_reg; // ac count and horizontal sync width
  reg [2:0] ctrl5_reg; // self refresh and swaps
  reg [31:0] prdata_reg; // read data captured in setup phase
  reg slverr_reg; // unmapped address flag
  // ----------------------------------------------------------------------
  // decoded fields
  // ----------------------------------------------------------------------
  wire enable = ctrl1_reg[`LPU_C1_ENABLE];
  wire [3:0] bpp = ctrl1_reg[`LPU_C1_BPP];
  wire active_panel = (ctrl1_reg[`LPU_C1_PANEL] == `LPU_PANEL_ACTIVE);
  wire ac_sel = ctrl1_reg[`LPU_C1_ACSEL];
  wire [9:0] divider = ctrl1_reg[`LPU_C1_DIV];
  wire [7:0] vbp = ctrl2_reg[`LPU_C2_VBP];
  wire [9:0] vsize = ctrl2_reg[`LPU_C2_VSIZE];
  wire [7:0] vfp = ctrl2_reg[`LPU_C2_VFP];
  wire [5:0] vsw = ctrl2_reg[`LPU_C2_VSW];
  wire [7:0] hbp = ctrl3_reg[`LPU_C3_HBP];
  wire [10:0] hsize = ctrl3_reg[`LPU_C3_HSIZE];
  wire [7:0] hfp = ctrl3_reg[`LPU_C3_HFP];
  wire [7:0] ac_count = ctrl4_reg[`LPU_C4_ACCNT];
  wire [7:0] hsw = ctrl4_reg[`LPU_C4_HSW];
  wire sr_request = ctrl5_reg[`LPU_C5_SELF_REFRESH_ENABLE];
  // ----------------------------------------------------------------------
  // timing state
  // ----------------------------------------------------------------------
  reg [9:0] div_cnt_reg; // bus cycles within a half pixel period
  reg pclk_reg; // internal pixel clock, keeps running in self refresh
  reg pclk_out_reg; // pixel clock as seen on the pin
  reg [12:0] h_cnt_reg; // pixel position in the line
  reg [11:0] v_cnt_reg; // line position in the frame
  reg [9:0] line_count_status_reg; // visible lines left in the frame
  reg sr_active_reg; // self refresh in force
  reg ac_bias_reg; // ac bias level
  reg [7:0] ac_cnt_reg; // line pulses since the last toggle
  reg frame_reg; // frame pulse / vertical sync
  reg line_reg; // line pulse / horizontal sync
  reg den_reg; // data enable
  reg line_end_out_reg; // line end strobe
  reg [15:0] vd_reg; // video data on the pins
  // ----------------------------------------------------------------------
  // pixel buffer state
  // ----------------------------------------------------------------------
  reg [95:0] grp_reg; // up to three words of one pixel group
  reg [1:0] fill_reg; // words held in the group
  reg [4:0] idx_reg; // next pixel inside the group
  wire [15:0] pix_sel; // pixel picked from the group
  // ----------------------------------------------------------------------
  // pixel clock divider
  // ----------------------------------------------------------------------
  // active panels use divider+1 bus cycles per half period, passive use
  // the divider itself, never less than one
  wire [10:0] half_cycles = active_panel ? ({1'b0, divider} + 11'h001) :
    ((divider < `LPU_STN_MIN_DIV) ? {1'b0, `LPU_STN_MIN_DIV} : {1'b0, divider});
  wire half_done = ({1'b0, div_cnt_reg} + 11'h001 >= half_cycles);
  wire pix_tick = enable & half_done & pclk_reg; // falling edge of pixel clock
  // ----------------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------------
  // sync widths are field+1, porches as programmed, sizes are field+1
  wire [12:0] h_vis_start = {5'h00, hsw} + 13'h0001 + {5'h00, hbp};
  wire [12:0] h_vis_end = h_vis_start + {2'h0, hsize} + 13'h0001;
  wire [12:0] h_total = h_vis_end + {5'h00, hfp};
  wire [11:0] v_vis_start = {6'h00, vsw} + 12'h001 + {4'h0, vbp};
  wire [11:0] v_vis_end = v_vis_start + {2'h0, vsize} + 12'h001;
  wire [11:0] v_total = v_vis_end + {4'h0, vfp};
  wire line_last = (h_cnt_reg + 13'h0001 >= h_total);
  wire frame_last = (v_cnt_reg + 12'h001 >= v_total);
  wire h_visible = (h_cnt_reg >= h_vis_start) && (h_cnt_reg < h_vis_end);
  wire v_visible = (v_cnt_reg >= v_vis_start) && (v_cnt_reg < v_vis_end);
  wire visible = h_visible & v_visible;
  // position the counters reach at the next tick, so the pixel loaded at the
  // falling clock lines up with the data enable seen at the following rise
  wire [12:0] h_next = line_last ? 13'h0000 : h_cnt_reg + 13'h0001;
  wire [11:0] v_next = line_last ? (frame_last ? 12'h000 : v_cnt_reg + 12'h001) : v_cnt_reg;
  wire visible_next = (h_next >= h_vis_start) && (h_next < h_vis_end) &&
    (v_next >= v_vis_start) && (v_next < v_vis_end);
  wire line_tick = pix_tick & line_last; // end of every line
  wire frame_tick = line_tick & frame_last; // end of every frame
  // ----------------------------------------------------------------------
  // group size per mode
  // ----------------------------------------------------------------------
  // words per group and last pixel index, used by fetch and output
  function [6:0] lpu_group_shape;
    input [3:0] mode;
    begin
      case (mode)
        `LPU_BPP_P12: lpu_group_shape = {2'h3, 5'h07};
        `LPU_BPP_A16: lpu_group_shape = {2'h1, 5'h01};
        `LPU_BPP_P8, `LPU_BPP_A8: lpu_group_shape = {2'h1, 5'h03};
        `LPU_BPP_P4, `LPU_BPP_A4: lpu_group_shape = {2'h1, 5'h07};
        `LPU_BPP_P2, `LPU_BPP_A2: lpu_group_shape = {2'h1, 5'h0f};
        default: lpu_group_shape = {2'h1, 5'h1f};
      endcase
    end
  endfunction
  wire [6:0] shape = lpu_group_shape(bpp);
  wire [1:0] grp_words = shape[6:5];
  wire [4:0] grp_last = shape[4:0];
  wire grp_full = (fill_reg == grp_words);
  // fetch stalls while self refresh holds the picture
  assign FRAME_WORD_READY = enable & ~grp_full & ~sr_active_reg;
  wire word_take = FRAME_WORD_READY & FRAME_WORD_VALID;
  // no pixel is taken unless the pin clock showed a full high phase first
  wire pix_take = pix_tick & visible_next & ~sr_active_reg & grp_full & pclk_out_reg;
  // ----------------------------------------------------------------------
  // pixel picker
  // ----------------------------------------------------------------------
  lpu_unpack u_unpack (
    .group_words(grp_reg),
    .pixel_index(idx_reg),
    .bpp_mode(bpp),
    .byte_swap(ctrl5_reg[`LPU_C5_BSWAP]),
    .halfword_swap(ctrl5_reg[`LPU_C5_HWSWAP]),
    .pixel(pix_sel)
  );
  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  wire setup = PSEL & ~PENABLE;
  wire wr_access = PSEL & PENABLE & PWRITE;
  // address check behind the error flag at setup; the write path decodes PADDR itself
  function lpu_mapped;
    input [11:0] a;
    begin
      lpu_mapped = (a == `LPU_OFS_CTRL1) || (a == `LPU_OFS_CTRL2) ||
        (a == `LPU_OFS_CTRL3) || (a == `LPU_OFS_CTRL4) || (a == `LPU_OFS_CTRL5);
    end
  endfunction
  // read data and error captured at setup, shown through the access phase
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      prdata_reg <= `LPU_RST_WORD;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      slverr_reg <= ~lpu_mapped(PADDR);
      case (PADDR)
        `LPU_OFS_CTRL1: begin
          prdata_reg <= {4'h0, line_count_status_reg, ctrl1_reg[17:0]};
        end
        `LPU_OFS_CTRL2: prdata_reg <= ctrl2_reg;
        `LPU_OFS_CTRL3: prdata_reg <= ctrl3_reg;
        `LPU_OFS_CTRL4: prdata_reg <= ctrl4_reg;
        `LPU_OFS_CTRL5: begin
          prdata_reg <= {22'h000000, visible, sr_active_reg, 5'h00, ctrl5_reg};
        end
        default: prdata_reg <= `LPU_RST_WORD;
      endcase
    end
  end
  // register writes take effect at the access edge
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl1_reg <= `LPU_RST_WORD;
      ctrl2_reg <= `LPU_RST_WORD;
      ctrl3_reg <= `LPU_RST_WORD;
      ctrl4_reg <= `LPU_RST_WORD;
      ctrl5_reg <= 3'h0;
    end else if (wr_access) begin
      case (PADDR)
        `LPU_OFS_CTRL1: ctrl1_reg <= {14'h0000, PWDATA[17:0]}; // line count is read only
        `LPU_OFS_CTRL2: ctrl2_reg <= PWDATA;
        `LPU_OFS_CTRL3: ctrl3_reg <= {PWDATA[31:24], 5'h00, PWDATA[18:0]};
        `LPU_OFS_CTRL4: ctrl4_reg <= {16'h0000, PWDATA[15:0]};
        `LPU_OFS_CTRL5: ctrl5_reg <= PWDATA[2:0];
        default: ctrl5_reg <= ctrl5_reg; // unmapped writes are dropped
      endcase
    end
  end
  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & slverr_reg;
  // ----------------------------------------------------------------------
  // pixel clock
  // ----------------------------------------------------------------------
  // the divider runs only from SYS_CLK, so the block keeps working when the
  // system feeds it alone with a slowed clock
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_cnt_reg <= 10'h000;
      pclk_reg <= 1'b0;
      pclk_out_reg <= 1'b0;
    end else if (!enable) begin
      div_cnt_reg <= 10'h000;
      pclk_reg <= 1'b0;
      pclk_out_reg <= 1'b0;
    end else begin
      if (half_done) begin
        div_cnt_reg <= 10'h000;
        pclk_reg <= ~pclk_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + 10'h001;
      end
      // pin clock held low while self refresh holds the panel; it only moves
      // at internal transitions, so leaving self refresh gives no short pulse
      if (half_done) begin
        pclk_out_reg <= ~pclk_reg & ~sr_active_reg;
      end else begin
        pclk_out_reg <= pclk_out_reg & ~sr_active_reg;
      end
    end
  end
  // ----------------------------------------------------------------------
  // line and frame counters
  // ----------------------------------------------------------------------
  // counters keep stepping in self refresh so sync pulses continue
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      h_cnt_reg <= 13'h0000;
      v_cnt_reg <= 12'h000;
      line_count_status_reg <= 10'h000;
    end else if (!enable) begin
      h_cnt_reg <= 13'h0000;
      v_cnt_reg <= 12'h000;
      line_count_status_reg <= vsize;
    end else if (pix_tick) begin
      if (line_last) begin
        h_cnt_reg <= 13'h0000;
        v_cnt_reg <= frame_last ? 12'h000 : v_cnt_reg + 12'h001;
        if (frame_last) begin
          line_count_status_reg <= vsize;
        end else if (v_visible && line_count_status_reg != 10'h000) begin
          line_count_status_reg <= line_count_status_reg - 10'h001;
        end
      end else begin
        h_cnt_reg <= h_cnt_reg + 13'h0001;
      end
    end
  end
  // ----------------------------------------------------------------------
  // self refresh control
  // ----------------------------------------------------------------------
  // entry waits for a line boundary, exit follows the bit at once
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sr_active_reg <= 1'b0;
    end else if (!sr_request || !enable) begin
      sr_active_reg <= 1'b0;
    end else if (line_tick) begin
      sr_active_reg <= 1'b1;
    end
  end
  // ----------------------------------------------------------------------
  // sync, enable and ac bias outputs
  // ----------------------------------------------------------------------
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      frame_reg <= 1'b0;
      line_reg <= 1'b0;
      den_reg <= 1'b0;
      line_end_out_reg <= 1'b0;
      ac_bias_reg <= 1'b0;
      ac_cnt_reg <= 8'h00;
    end else if (!enable) begin
      frame_reg <= 1'b0;
      line_reg <= 1'b0;
      den_reg <= 1'b0;
      line_end_out_reg <= 1'b0;
      ac_bias_reg <= 1'b0;
      ac_cnt_reg <= 8'h00;
    end else begin
      if (active_panel) begin
        // syncs at the head of the frame and of each line
        frame_reg <= (v_cnt_reg <= {6'h00, vsw});
        line_reg <= (h_cnt_reg <= {5'h00, hsw});
        den_reg <= visible & ~sr_active_reg;
      end else begin
        // passive: frame pulse spans the first line, line pulse follows data
        frame_reg <= (v_cnt_reg == 12'h000);
        line_reg <= (h_cnt_reg >= h_vis_end);
        den_reg <= 1'b0;
      end
      line_end_out_reg <= line_tick;
      if (ac_sel) begin
        if (line_tick) begin
          if (ac_cnt_reg >= ac_count) begin
            ac_cnt_reg <= 8'h00;
            ac_bias_reg <= ~ac_bias_reg;
          end else begin
            ac_cnt_reg <= ac_cnt_reg + 8'h01;
          end
        end
      end else begin
        ac_cnt_reg <= 8'h00;
        if (frame_tick) begin
          ac_bias_reg <= ~ac_bias_reg;
        end
      end
    end
  end
  // ----------------------------------------------------------------------
  // word buffer and pixel output
  // ----------------------------------------------------------------------
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      grp_reg <= 96'h0;
      fill_reg <= 2'h0;
      idx_reg <= 5'h00;
      vd_reg <= 16'h0000;
    end else if (!enable) begin
      fill_reg <= 2'h0;
      idx_reg <= 5'h00;
      vd_reg <= 16'h0000;
    end else begin
      if (word_take) begin
        // words fill the group from the top down
        case (fill_reg)
          2'h0: grp_reg[95:64] <= FRAME_WORD;
          2'h1: grp_reg[63:32] <= FRAME_WORD;
          default: grp_reg[31:0] <= FRAME_WORD;
        endcase
        fill_reg <= fill_reg + 2'h1;
      end else if (pix_take) begin
        vd_reg <= pix_sel;
        if (idx_reg >= grp_last) begin
          idx_reg <= 5'h00;
          fill_reg <= 2'h0;
        end else begin
          idx_reg <= idx_reg + 5'h01;
        end
      end else if (pix_tick & visible_next & ~sr_active_reg & pclk_out_reg) begin
        vd_reg <= 16'h0000; // underrun shows black
      end
      // in self refresh vd_reg is left untouched, holding the last pixel
    end
  end
  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  assign VIDEO_DATA_OUT = vd_reg;
  assign PIXEL_CLOCK_OUT = pclk_out_reg;
  assign FRAME_PULSE_OUT = frame_reg;
  assign LINE_PULSE_OUT = line_reg;
  assign DATA_ENABLE_OUT = den_reg;
  assign LINE_END_OUT = line_end_out_reg;
  assign AC_BIAS_OUT = ac_bias_reg;
endmodule // lpu_top
`default_nettype wire

// ==== dv/lpu_top_properties.sv ====
/*
  port checker for the pixel unpack and timing block.
  assumes active panel tests with a divider of at least one.
*/
`timescale 1ns/1ps
`default_nettype none
module lpu_top_properties (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [15:0] VIDEO_DATA_OUT,
  input wire logic PIXEL_CLOCK_OUT,
  input wire logic FRAME_PULSE_OUT,
  input wire logic LINE_PULSE_OUT,
  input wire logic DATA_ENABLE_OUT,
  input wire logic LINE_END_OUT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // ----------------------------------------------------------------------
  // helper: cycles the pixel clock has stayed low
  // ----------------------------------------------------------------------
  logic [3:0] low_cnt_reg;
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) low_cnt_reg <= 4'h0;
    else if (PIXEL_CLOCK_OUT) low_cnt_reg <= 4'h0;
    else if (low_cnt_reg != 4'hf) low_cnt_reg <= low_cnt_reg + 4'h1;
  end
  sequence s_quiet3;
    !LINE_END_OUT [*3];
  endsequence
  AST_PREADY_HIGH: assert property (PREADY) else $error("pready low");
  AST_SLVERR_ACCESS: assert property (PSLVERR |-> PSEL && PENABLE) else $error("slverr");
  AST_UNMAPPED_ZERO: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("unmapped read data not zero");
  AST_LINE_END_PULSE: assert property (LINE_END_OUT |=> s_quiet3) else $error("line end");
  AST_DATA_HELD_HIGH: assert property (PIXEL_CLOCK_OUT && $past(PIXEL_CLOCK_OUT)
    |-> $stable(VIDEO_DATA_OUT)) else $error("data moved while pixel clock high");
  AST_DEN_NOT_SYNC: assert property (DATA_ENABLE_OUT |-> !LINE_PULSE_OUT && !FRAME_PULSE_OUT)
    else $error("data enable inside sync");
  AST_PCLK_HALF: assert property ($rose(PIXEL_CLOCK_OUT) |-> PIXEL_CLOCK_OUT [*2])
    else $error("pixel clock high phase too short");
  AST_SR_DATA_HOLD: assert property (low_cnt_reg > 4'h3 |-> $stable(VIDEO_DATA_OUT))
    else $error("data moved while pixel clock stopped");
endmodule // lpu_top_properties
bind lpu_top lpu_top_properties u_props (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .VIDEO_DATA_OUT(VIDEO_DATA_OUT), .PIXEL_CLOCK_OUT(PIXEL_CLOCK_OUT),
  .FRAME_PULSE_OUT(FRAME_PULSE_OUT), .LINE_PULSE_OUT(LINE_PULSE_OUT),
  .DATA_ENABLE_OUT(DATA_ENABLE_OUT), .LINE_END_OUT(LINE_END_OUT));
`default_nettype wire

// ==== dv/lpu_panel_model.sv ====
/*
  panel driver model: a shift register clocked by the pixel clock.
  assumes data and enable settle before the pixel clock rises.
*/
`timescale 1ns/1ps
`default_nettype none
module lpu_panel_model (
  input wire logic pclk,
  input wire logic den,
  input wire logic [15:0] vd
);
  logic [15:0] px [0:255]; // captured visible pixels
  int n = 0; // pixels captured so far
  // shift in one visible pixel per rising pixel clock
  always @(posedge pclk) begin
    if (den && n < 256) begin
      px[n] <= vd;
      n <= n + 1;
    end
  end
endmodule // lpu_panel_model
`default_nettype wire

// ==== dv/lpu_top_tb_top.sv ====
/*
  testbench: apb register tasks and timing measurements.
  assumes the checker is bound and a free running word feeder.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpu_consts.vh"
module lpu_top_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, fw = {4'ha, 12'h000, 4'h5, 12'h000};
  logic pready, pslverr, fw_ready, take = 1'b0, pclk, fp, lp, den, le, acb, err;
  logic [15:0] vd, hold;
  logic [11:0] idx = 12'h000;
  int n_fail = 0, checked = 0, n, k, hi, fr, n0;
  initial forever #2.5 clk = ~clk;
  lpu_top uut (.SYS_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FRAME_WORD(fw), .FRAME_WORD_VALID(1'b1), .FRAME_WORD_READY(fw_ready),
    .VIDEO_DATA_OUT(vd), .PIXEL_CLOCK_OUT(pclk), .FRAME_PULSE_OUT(fp), .LINE_PULSE_OUT(lp),
    .DATA_ENABLE_OUT(den), .LINE_END_OUT(le), .AC_BIAS_OUT(acb));
  lpu_panel_model u_model (.pclk(pclk), .den(den), .vd(vd));
  // feeder: word i carries i in both halves, tagged a (upper) and 5 (lower)
  always @(negedge clk) take <= fw_ready;
  always @(posedge clk) if (take) begin
    idx <= idx + 12'h001;
    fw <= {4'ha, idx + 12'h001, 4'h5, idx + 12'h001};
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk) penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 50) begin n_fail++; report_and_stop; end
  endtask
  function logic pick(input int w);
    case (w) 0: pick = pclk; 1: pick = lp; 2: pick = fp; default: pick = acb; endcase
  endfunction
  // cycles between two rising edges of the chosen output
  task period(input int w, input int exp, input string nm);
    int r, c, i;
    logic p;
    r = 0; c = 0; p = pick(w);
    for (i = 0; i < 4000 && r < 2; i++) begin
      @(negedge clk);
      if (pick(w) && !p) r++;
      if (r == 1) c++;
      p = pick(w);
    end
    if (r < 2) begin n_fail++; report_and_stop; end
    check(nm, c, exp);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, `LPU_OFS_CTRL2, 0); check("ctrl2 reset", rd, `LPU_RST_WORD);
    apb(0, 12'h020, 0); check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    apb(1, `LPU_OFS_CTRL1, 32'h0ffc_0000); apb(0, `LPU_OFS_CTRL1, 0);
    check("line count read only", rd, 32'h0);
    apb(1, `LPU_OFS_CTRL2, 32'h0100_4040);
    apb(0, `LPU_OFS_CTRL1, 0); check("line count reload", rd, 32'h0004_0000);
    apb(1, `LPU_OFS_CTRL3, 32'h0100_0301);
    apb(1, `LPU_OFS_CTRL4, 32'h0);
    apb(1, `LPU_OFS_CTRL1, 32'h0000_0279);
    period(0, 6, "pixel clock");
    period(1, 42, "line period");
    period(2, 210, "frame period");
    for (k = 0; k < 8; k++) check("pixel", u_model.px[k],
      {k[0] ? 4'h5 : 4'ha, k[12:1]});
    period(3, 420, "ac bias per frame");
    apb(1, `LPU_OFS_CTRL1, 32'h0000_02f9);
    period(3, 84, "ac bias per line");
    n0 = u_model.n;
    apb(1, `LPU_OFS_CTRL5, 32'h4);
    period(2, 210, "frame period"); period(2, 210, "frame period");
    for (k = n0 + 2; u_model.px[k][15:12] !== 4'h5 && k < n0 + 8; k++);
    check("swap second", u_model.px[k + 1], {4'ha, u_model.px[k][11:0]});
    apb(1, `LPU_OFS_CTRL1, 32'h0000_02f1);
    period(2, 210, "mono frame");
    apb(1, `LPU_OFS_CTRL5, 32'h5);
    repeat (2) @(negedge clk);
    for (k = 0; k < 100 && le !== 1'b1; k++) @(negedge clk);
    check("line end", le, 1);
    repeat (3) @(negedge clk);
    hold = vd; hi = 0; fr = 0;
    for (k = 0; k < 300; k++) begin
      @(negedge clk);
      hi += pclk; fr += fp;
    end
    check("refresh clock", hi, 0); check("refresh data", vd, hold);
    check("refresh frame", fr > 0, 1); check("refresh ready", fw_ready, 0);
    apb(1, `LPU_OFS_CTRL5, 32'h4);
    period(0, 6, "pixel clock resumed");
    report_and_stop;
  end
endmodule // lpu_top_tb_top
`default_nettype wire
